/* File: bench/tbd_decode_props.sv */
// Port assertions for the instruction decoder.
// Bound onto tbd_insn_decode below.
`default_nettype none
module tbd_decode_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [11:0] insnWord,
  input wire logic insnValid,
  input wire logic insnAccept,
  input wire logic [7:0] accValue,
  input wire logic zeroFlag,
  input wire logic [8:0] jumpTargetOut,
  input wire logic jumpTaken,
  input wire logic orImmDone,
  input wire logic orRegDone
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_tk; insnAccept && insnValid; endsequence
  sequence s_jmp; s_tk ##0 insnWord[11:9] == 3'h5; endsequence
  property p_gap; s_tk |=> !insnAccept [*3]; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_jgap; s_jmp |=> !insnAccept [*7]; endproperty
  a_jgap: assert property (p_jgap) else $error("jump gap");
  property p_imm; s_tk ##0 insnWord[11:8] == 4'hd |-> ##5 orImmDone;
  endproperty
  a_imm: assert property (p_imm) else $error("imm done");
  property p_acc;
    orImmDone |-> accValue == ($past(accValue) | $past(insnWord[7:0], 5));
  endproperty
  a_acc: assert property (p_acc) else $error("imm acc");
  property p_zero; orImmDone |-> zeroFlag == (accValue == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_reg; s_tk ##0 insnWord[11:6] == 6'h04 |-> ##5 orRegDone;
  endproperty
  a_reg: assert property (p_reg) else $error("reg done");
  property p_keep;
    s_tk ##0 insnWord[11:5] == 7'h09 |-> ##5 accValue == $past(accValue);
  endproperty
  a_keep: assert property (p_keep) else $error("reg keep");
  property p_jmp;
    s_jmp |-> ##5 jumpTaken && jumpTargetOut == $past(insnWord[8:0], 5);
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump");
endmodule // tbd_decode_props
bind tbd_insn_decode tbd_decode_props u_props (.core_clk, .reset_n,
  .insnWord, .insnValid, .insnAccept, .accValue, .zeroFlag,
  .jumpTargetOut, .jumpTaken, .orImmDone, .orRegDone);
`default_nettype wire

/* File: bench/tbd_prog_mem.sv */
// Program memory model that feeds instruction words to the decoder.
// The bench loads mem and len; stall holds the next word back.
`default_nettype none
module tbd_prog_mem (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic insnAccept,
  input wire logic stall,
  output logic [11:0] insnWord,
  output logic insnValid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] mem [0:31];
  int len = 0;
  int pc = 0;
  initial foreach (mem[i]) mem[i] = 12'h5a5;
  always @(posedge core_clk)
    if (!reset_n) pc <= 0;
    else if (insnAccept && insnValid) pc <= pc + 1;
  assign insnValid = pc < len && !stall;
  // An idle bus shows the inverted word so a stale value never matches.
  assign insnWord = insnValid ? mem[pc] : ~mem[pc];
endmodule // tbd_prog_mem
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the decoder fed by the program memory model.
// Assumes design, checker and model files are compiled first.
`default_nettype none
`define CHK(n, e, g) cmp(n, e, g)
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0;
  logic reset_n = 0;
  logic stall = 0;
  logic [11:0] insnWord;
  logic insnValid, insnAccept, zeroFlag, jumpTaken, orImmDone, orRegDone;
  logic [7:0] accValue, litOut;
  logic [4:0] fileIndexOut;
  logic [2:0] bitPosOut;
  logic [8:0] jumpTargetOut;
  int fail_count = 0;
  int checked = 0;
  tbd_insn_decode u_dut (.core_clk, .reset_n, .insnWord, .insnValid,
    .insnAccept, .accValue, .zeroFlag, .fileIndexOut, .bitPosOut,
    .litOut, .jumpTargetOut, .jumpTaken, .orImmDone, .orRegDone);
  tbd_prog_mem u_mem (.core_clk, .reset_n, .insnAccept, .stall,
    .insnWord, .insnValid);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic cmp(string n, logic [11:0] e, logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize(bit late);
    if (late) fail_count++;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Loads words behind the last ones, answers slowly, then runs them out.
  task automatic run(logic [11:0] w[$]);
    int n;
    n = 0;
    foreach (w[i]) u_mem.mem[u_mem.len + i] <= w[i];
    u_mem.len <= u_mem.len + w.size();
    stall <= 1;
    repeat (5) @(posedge core_clk);
    stall <= 0;
    while (u_mem.pc != u_mem.len && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 200)
      summarize(1);
    else
      repeat (6) @(posedge core_clk);
  endtask
  task automatic t_reg;
    run('{12'h11f});
    `CHK("zero", 1'h1, zeroFlag);
    `CHK("acc", 8'h00, accValue);
    run('{12'hd13, 12'h13c});
    `CHK("acc", 8'h13, accValue);
    `CHK("zero", 1'h0, zeroFlag);
    `CHK("file", 5'h1c, fileIndexOut);
    `CHK("bit", 3'h1, bitPosOut);
    `CHK("freg", 8'h13, u_dut.fileMem[28]);
    `CHK("fother", 8'h00, u_dut.fileMem[31]);
  endtask
  task automatic t_imm;
    run('{12'hd9a, 12'hd35});
    `CHK("acc", 8'hbf, accValue);
    `CHK("zero", 1'h0, zeroFlag);
    `CHK("lit", 8'h35, litOut);
  endtask
  task automatic t_jump;
    run('{12'hba5, 12'hd40});
    `CHK("target", 9'h1a5, jumpTargetOut);
    `CHK("acc", 8'hff, accValue);
    `CHK("file", 5'h00, fileIndexOut);
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1;
    t_reg;
    t_imm;
    t_jump;
    summarize(0);
  end
endmodule // testbench
`default_nettype wire

/* File: design/tbd_decode_regs.vh */
// Constants for the twelve-bit instruction decoder: field positions,
// opcode patterns, cycle timing and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef TBD_DECODE_REGS_VH
`define TBD_DECODE_REGS_VH
`define TBD_BYTE_OP_HI 11
`define TBD_BYTE_OP_LO 6
`define TBD_DEST_BIT 5
`define TBD_FILE_HI 4
`define TBD_FILE_LO 0
`define TBD_BIT_OP_LO 8
`define TBD_BITPOS_HI 7
`define TBD_BITPOS_LO 5
`define TBD_LIT_OP_LO 8
`define TBD_LIT_HI 7
`define TBD_JMP_OP_LO 9
`define TBD_JMP_HI 8
`define TBD_OP_OR_IMM 4'hd
`define TBD_OP_OR_REG 6'h04
`define TBD_OP_JUMP 3'h5
`define TBD_OSC_PER_CYCLE 3'h4
`define TBD_ACC_RESET 8'h00
`define TBD_FILE_RESET 8'h00
`define TBD_FILE_COUNT 32
`endif

/* File: design/tbd_field_split.v */
// Splits a 12-bit instruction word into the fields of each format.
// Assumes a stable instruction word; purely combinational.
`default_nettype none
`include "tbd_decode_regs.vh"
module tbd_field_split (
  input wire [11:0] insnWord,
  output wire [5:0] byteOpcode,
  output wire destSel,
  output wire [4:0] fileIndex,
  output wire [3:0] bitOpcode,
  output wire [2:0] bitPos,
  output wire [3:0] litOpcode,
  output wire [7:0] litValue,
  output wire [2:0] jumpOpcode,
  output wire [8:0] jumpTarget
);
  assign byteOpcode = insnWord[`TBD_BYTE_OP_HI:`TBD_BYTE_OP_LO];
  assign destSel = insnWord[`TBD_DEST_BIT];
  assign fileIndex = insnWord[`TBD_FILE_HI:`TBD_FILE_LO];
  assign bitOpcode = insnWord[11:`TBD_BIT_OP_LO];
  assign bitPos = insnWord[`TBD_BITPOS_HI:`TBD_BITPOS_LO];
  assign litOpcode = insnWord[11:`TBD_LIT_OP_LO];
  assign litValue = insnWord[`TBD_LIT_HI:0];
  assign jumpOpcode = insnWord[11:`TBD_JMP_OP_LO];
  assign jumpTarget = insnWord[`TBD_JMP_HI:0];
endmodule // tbd_field_split
`default_nettype wire

/* File: design/tbd_insn_decode.v */
// Instruction decoder and inclusive-OR execution unit of a small core.
// Assumes program memory presents a word on insnWord, held for the whole
// instruction cycle, and insnValid from logic on core_clk.
// Summary of operation
// - Byte format: opcode bits 11..6, destination bit 5, file index 4..0.
// - Destination 0 writes accumulator; 1 writes the addressed file register.
// - Literal format: opcode 11..8, eight-bit constant 7..0.
// - Jump format: opcode 11..9, nine-bit target 8..0.
// - Upper nibble 1101 ORs constant into accumulator in one cycle.
// - OR-immediate updates zero flag and is one program word.
// - Pattern 0001 00df ffff ORs accumulator with file register, updates zero.
// - OR-register destination 0 goes to accumulator, 1 to file register.
// - Instruction cycle is four oscillator periods; jumps take two cycles.
// - The file index selects one of 32 registers, 0x00 to 0x1F.
`default_nettype none
`include "tbd_decode_regs.vh"
module tbd_insn_decode (
  input wire core_clk,
  input wire reset_n,
  input wire [11:0] insnWord,
  input wire insnValid,
  output wire insnAccept,
  output reg [7:0] accValue,
  output reg zeroFlag,
  output reg [4:0] fileIndexOut,
  output reg [2:0] bitPosOut,
  output reg [7:0] litOut,
  output reg [8:0] jumpTargetOut,
  output reg jumpTaken,
  output reg orImmDone,
  output reg orRegDone
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_FLUSH = 3'b100;

  wire [5:0] byteOpcode;
  wire destSel;
  wire [4:0] fileIndex;
  wire [2:0] bitPos;
  wire [3:0] litOpcode;
  wire [7:0] litValue;
  wire [2:0] jumpOpcode;
  wire [8:0] jumpTarget;

  tbd_field_split fieldSplit (
    .insnWord(insnWord),
    .byteOpcode(byteOpcode),
    .destSel(destSel),
    .fileIndex(fileIndex),
    .bitOpcode(),
    .bitPos(bitPos),
    .litOpcode(litOpcode),
    .litValue(litValue),
    .jumpOpcode(jumpOpcode),
    .jumpTarget(jumpTarget)
  );

  reg [7:0] fileMem [0:`TBD_FILE_COUNT-1];
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] phase_reg;
  reg orImm_reg;
  reg orReg_reg;
  reg jump_reg;
  reg destFile_reg;
  reg [8:0] target_reg;
  reg [7:0] accValue_next;
  reg zeroFlag_next;
  reg [8:0] jumpTargetOut_next;
  reg jumpTaken_next;
  reg orImmDone_next;
  reg orRegDone_next;

  wire [2:0] lastPhase;
  wire phaseEnd;
  wire execEnd;
  wire takeWord;
  wire decOrImm;
  wire decOrReg;
  wire decJump;
  wire [7:0] fileValue;
  wire [7:0] operand;
  wire [7:0] orResult;
  wire orZero;
  wire fileWrite;

  assign lastPhase = `TBD_OSC_PER_CYCLE - 3'h1;
  assign phaseEnd = (phase_reg == lastPhase);
  assign execEnd = phaseEnd && (state_reg == ST_EXEC);
  // The next word is fetched while the current one executes, so plain
  // instructions issue once per instruction cycle; a jump gives up the
  // fetch slot of its own execute cycle and so costs a second cycle.
  assign insnAccept = phaseEnd && (state_reg == ST_IDLE ||
    state_reg == ST_FLUSH || (state_reg == ST_EXEC && !jump_reg));
  assign takeWord = insnAccept && insnValid;
  assign decOrImm = (litOpcode == `TBD_OP_OR_IMM);
  assign decOrReg = (byteOpcode == `TBD_OP_OR_REG);
  assign decJump = (jumpOpcode == `TBD_OP_JUMP);
  assign fileValue = fileMem[fileIndexOut];
  assign operand = orImm_reg ? litOut : fileValue;
  assign orResult = accValue | operand;
  assign orZero = (orResult == 8'h00);
  assign fileWrite = execEnd && orReg_reg && destFile_reg;

  // The flush cycle after a jump is also a fetch slot.
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_FLUSH:
        if (phaseEnd)
          state_next = insnValid ? ST_EXEC : ST_IDLE;
      ST_EXEC:
        if (phaseEnd)
        begin
          if (jump_reg)
            state_next = ST_FLUSH;
          else
            state_next = insnValid ? ST_EXEC : ST_IDLE;
        end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Results land on the last phase of the execute cycle; words other than
  // the two OR forms and the jump leave accumulator, zero flag and jump target untouched.
  always @*
  begin
    accValue_next = accValue;
    zeroFlag_next = zeroFlag;
    jumpTargetOut_next = jumpTargetOut;
    jumpTaken_next = 1'b0;
    orImmDone_next = 1'b0;
    orRegDone_next = 1'b0;
    if (execEnd)
    begin
      if (orImm_reg)
      begin
        accValue_next = orResult;
        zeroFlag_next = orZero;
        orImmDone_next = 1'b1;
      end
      else if (orReg_reg)
      begin
        if (!destFile_reg)
          accValue_next = orResult;
        zeroFlag_next = orZero;
        orRegDone_next = 1'b1;
      end
      else if (jump_reg)
      begin
        jumpTargetOut_next = target_reg;
        jumpTaken_next = 1'b1;
      end
    end
  end

  // Only an OR-register word with its destination bit set writes a file
  // register, and only the one that its index selects.
  genvar gi;
  generate
    for (gi = 0; gi < `TBD_FILE_COUNT; gi = gi + 1)
    begin : fileReg
      always @(posedge core_clk)
      begin
        if (!reset_n)
          fileMem[gi] <= `TBD_FILE_RESET;
        else if (fileWrite && fileIndexOut == gi)
          fileMem[gi] <= orResult;
      end
    end
  endgenerate

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= 3'h0;
      orImm_reg <= 1'b0;
      orReg_reg <= 1'b0;
      jump_reg <= 1'b0;
      destFile_reg <= 1'b0;
      target_reg <= 9'h000;
      accValue <= `TBD_ACC_RESET;
      zeroFlag <= 1'b0;
      fileIndexOut <= 5'h00;
      bitPosOut <= 3'h0;
      litOut <= 8'h00;
      jumpTargetOut <= 9'h000;
      jumpTaken <= 1'b0;
      orImmDone <= 1'b0;
      orRegDone <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phaseEnd ? 3'h0 : phase_reg + 3'h1;
      accValue <= accValue_next;
      zeroFlag <= zeroFlag_next;
      jumpTargetOut <= jumpTargetOut_next;
      jumpTaken <= jumpTaken_next;
      orImmDone <= orImmDone_next;
      orRegDone <= orRegDone_next;
      // The decode is captured with the word, so the bus may move on to
      // the next word while this one executes.
      if (takeWord)
      begin
        orImm_reg <= decOrImm;
        orReg_reg <= decOrReg;
        jump_reg <= decJump;
        destFile_reg <= destSel;
        target_reg <= jumpTarget;
        fileIndexOut <= fileIndex;
        bitPosOut <= bitPos;
        litOut <= litValue;
      end
    end
  end
endmodule // tbd_insn_decode
`default_nettype wire
